// ===== src/ecg_host_pkg.sv
package ecg_host_pkg;
   // Register offsets of the device outside.
   localparam logic [6:0] ADDR_NO_OPERATION = 7'h00;
   localparam logic [6:0] ADDR_PIN_STATE_WORD = 7'h06;
   localparam logic [6:0] ADDR_FIRST_LEAD_RESULT = 7'h11;
   localparam logic [6:0] ADDR_SECOND_LEAD_RESULT = 7'h12;
   localparam logic [6:0] ADDR_THIRD_LEAD_RESULT = 7'h13;
   localparam logic [6:0] ADDR_PACING_DETECT_RESULT = 7'h1a;
   localparam logic [6:0] ADDR_RESPIRATION_MAGNITUDE = 7'h1b;
   localparam logic [6:0] ADDR_RESPIRATION_PHASE = 7'h1c;
   localparam logic [6:0] ADDR_ELECTRODE_OFF_STATUS = 7'h1d;
   localparam logic [6:0] ADDR_FRAME_HEADER = 7'h40;
   localparam logic [6:0] ADDR_FRAME_CHECK_WORD = 7'h41;
   // Serial word layout.
   localparam int WORD_BITS = 32;
   localparam int SHORT_BITS = 16;
   localparam int RW_BIT = 31;
   localparam int ADDR_MSB = 30;
   localparam int ADDR_LSB = 24;
   localparam int DATA_MSB = 23;
   localparam int RESYNC_CLOCKS = 64;
   // Host own Wishbone registers (byte addresses).
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_RDATA = 4'hc;
   // Control bits.
   localparam int CTRL_DIV_LSB = 0;
   localparam int CTRL_DIV_W = 8;
   localparam int CTRL_SHORT = 8;
   localparam int CTRL_KEEP_CS = 9;
   localparam int CTRL_RESYNC = 10;
   localparam logic [7:0] DIV_RESET = 8'h04;
   // Status bits.
   localparam int ST_BUSY = 0;
   localparam int ST_READY = 1;
   localparam int ST_DONE = 2;
   localparam int ST_CMDREQ = 3;
   // Link clock limits.
   localparam int CLK_HZ = 10_000_000;
   localparam int SCLK_MAX_HZ = 40_000_000;
   localparam int HALF_MIN_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   // Last count of the settle gap between words, select high unless keep_cs_r is set.
   localparam logic [7:0] FLUSH_CYCLES = 8'h03;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_LOW = 3'b011,
      ST_HIGH = 3'b010,
      ST_END = 3'b110,
      ST_FLUSH = 3'b111
   } link_state_t;

   typedef struct packed {
      logic sclk;
      logic cs_low;
      logic mosi;
   } link_out_t;
endpackage

// ===== src/ecg_frame_host.sv
// Operation
// - Host never drives serial clock faster than 40 MHz.
// - With select tied low, 64 high clocks then a read realign words.
// - Host keeps serial clock high while chip select is high.
// - Host reads every word of an available packet; this host only reports frame_ready_low_i in status.
// - Command is 32 bits MSB first, 32 rising edges before select rises; with short_r set the host sends only 16.
// - Bit 31 read/write, bits 30..24 address, bits 23..0 data.
// - Framing starts with header read; zero words continue the frame.
// - Select may toggle per word or stay low through the frame.
// - Register read interleaves when sent in the final frame word.
// - Host clock at least frame rate times words times bits.
// - Clock crossing needs three internal cycles per transfer.
`timescale 1ns/1ps
module ecg_frame_host
   import ecg_host_pkg::*;
#(
   parameter int WIDTH_CMD = WORD_BITS
)
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Serial link to the device
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   input wire logic frame_ready_low_i
);

   link_state_t state_r;
   link_out_t link_r;
   logic [WIDTH_CMD-1:0] cmd_r;
   logic [WIDTH_CMD-1:0] tx_r;
   logic [WIDTH_CMD-1:0] rx_r;
   logic [31:0] rdata_r;
   logic [CTRL_DIV_W-1:0] div_r;
   logic [CTRL_DIV_W-1:0] cnt_r;
   logic [6:0] bit_r;
   logic short_r;
   logic keep_cs_r;
   logic resync_r;
   logic pend_r;
   logic done_r;
   logic [1:0] miso_s;
   logic [1:0] rdy_s;
   logic wb_hit;
   logic [6:0] word_len;
   logic [CTRL_DIV_W-1:0] half_cyc;

   function automatic logic [31:0] mask_bytes(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign wb_hit = cyc_i && stb_i && !ack_o;
   // Words are 16 bits when short_r is set, commands included; resync words are 64 clocks.
   assign word_len = resync_r ? 7'(RESYNC_CLOCKS)
      : (short_r ? 7'(SHORT_BITS) : 7'(WORD_BITS));
   assign half_cyc = (div_r < 8'(HALF_MIN_CYC)) ? 8'(HALF_MIN_CYC)
      : div_r;

   // Link inputs come from another domain.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         miso_s <= 2'h0;
         rdy_s <= 2'h3;
      end
      else if (ce_i)
      begin
         miso_s <= {miso_s[0], miso_i};
         rdy_s <= {rdy_s[0], frame_ready_low_i};
      end
   end

   // Wishbone acknowledge and read data.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end
      else if (ce_i)
      begin
         ack_o <= wb_hit;
         dat_o <= 32'h0;
         if (wb_hit && !we_i)
         begin
            case (adr_i)
               REG_CMD: dat_o <= cmd_r;
               REG_CTRL: dat_o <= {21'h0, resync_r, keep_cs_r, short_r, div_r};
               REG_STATUS: dat_o <= {28'h0, pend_r, done_r, !rdy_s[1],
                  state_r != ST_IDLE};
               REG_RDATA: dat_o <= rdata_r;
               default: dat_o <= 32'h0;
            endcase
         end
      end
   end

   // Control register.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_r <= DIV_RESET;
         short_r <= 1'b0;
         keep_cs_r <= 1'b0;
         resync_r <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wb_hit && we_i && adr_i == REG_CTRL)
         begin
            {resync_r, keep_cs_r, short_r, div_r} <=
               11'(mask_bytes({21'h0, resync_r, keep_cs_r, short_r, div_r},
               dat_i, sel_i));
         end
         else if (state_r == ST_END && resync_r)
         begin
            resync_r <= 1'b0;
         end
      end
   end

   // Command register; a write queues one word for the link.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cmd_r <= '0;
         pend_r <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wb_hit && we_i && adr_i == REG_CMD)
         begin
            cmd_r <= mask_bytes(cmd_r, dat_i, sel_i);
            pend_r <= 1'b1;
         end
         else if (state_r == ST_IDLE && pend_r)
         begin
            pend_r <= 1'b0;
         end
      end
   end

   // Serial engine: idle high clock, 32, 16 or 64 clocks per word, MSB first.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= ST_IDLE;
         link_r <= '{sclk: 1'b1, cs_low: 1'b0, mosi: 1'b1};
         cnt_r <= '0;
         bit_r <= '0;
         tx_r <= '0;
         rx_r <= '0;
         rdata_r <= 32'h0;
         done_r <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wb_hit && !we_i && adr_i == REG_STATUS)
         begin
            done_r <= 1'b0;
         end
         case (state_r)
            ST_IDLE:
            begin
               link_r.sclk <= 1'b1;
               if (pend_r)
               begin
                  tx_r <= resync_r ? '1 : cmd_r;
                  link_r.cs_low <= 1'b1;
                  bit_r <= '0;
                  cnt_r <= '0;
                  state_r <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               link_r.mosi <= resync_r ? 1'b1 : tx_r[WIDTH_CMD-1];
               if (cnt_r >= half_cyc - 8'h1)
               begin
                  cnt_r <= '0;
                  link_r.sclk <= 1'b0;
                  state_r <= ST_LOW;
               end
               else
               begin
                  cnt_r <= cnt_r + 8'h1;
               end
            end
            ST_LOW:
            begin
               if (cnt_r >= half_cyc - 8'h1)
               begin
                  // Rising edge: device samples here, host takes its bit.
                  cnt_r <= '0;
                  link_r.sclk <= 1'b1;
                  rx_r <= {rx_r[WIDTH_CMD-2:0], miso_s[1]};
                  bit_r <= bit_r + 7'h1;
                  state_r <= ST_HIGH;
               end
               else
               begin
                  cnt_r <= cnt_r + 8'h1;
               end
            end
            ST_HIGH:
            begin
               if (cnt_r >= half_cyc - 8'h1)
               begin
                  cnt_r <= '0;
                  if (bit_r >= word_len)
                  begin
                     state_r <= ST_END;
                  end
                  else
                  begin
                     // Falling edge: device updates its output.
                     tx_r <= {tx_r[WIDTH_CMD-2:0], 1'b1};
                     link_r.mosi <= resync_r ? 1'b1 : tx_r[WIDTH_CMD-2];
                     link_r.sclk <= 1'b0;
                     state_r <= ST_LOW;
                  end
               end
               else
               begin
                  cnt_r <= cnt_r + 8'h1;
               end
            end
            ST_END:
            begin
               // Short words land in the low half of the read register.
               rdata_r <= short_r ? {16'h0, rx_r[SHORT_BITS-1:0]}
                  : rx_r;
               done_r <= 1'b1;
               link_r.cs_low <= keep_cs_r;
               state_r <= ST_FLUSH;
            end
            ST_FLUSH:
            begin
               // Select stays high, or low when keep_cs_r is set, a few cycles so the device can settle.
               if (cnt_r >= FLUSH_CYCLES)
               begin
                  cnt_r <= '0;
                  state_r <= ST_IDLE;
               end
               else
               begin
                  cnt_r <= cnt_r + 8'h1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sclk_o <= 1'b1;
         cs_n_o <= 1'b1;
         mosi_o <= 1'b1;
      end
      else if (ce_i)
      begin
         sclk_o <= link_r.sclk;
         cs_n_o <= !link_r.cs_low;
         mosi_o <= link_r.mosi;
      end
   end

endmodule

// ===== sim/ecg_frame_host_monitor.sv
`timescale 1ns/1ps
module ecg_frame_host_monitor
(
   // Watched ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic sclk_o,
   input wire logic cs_n_o,
   input wire logic mosi_o
);
   logic sclk_q_r;
   logic [6:0] rise_r;
   // Counts rising serial clock edges within one selection.
   always_ff @(posedge clk_i)
   begin
      sclk_q_r <= sclk_o;
      if (rst_i || cs_n_o)
         rise_r <= 7'h00;
      else if (sclk_o && !sclk_q_r)
         rise_r <= rise_r + 7'h01;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && ce_i && !ack_o;
   endsequence
   a_ack_after_req: assert property (s_req |=> ack_o)
      else $error("no ack after request");
   a_ack_one_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_idle_clock_high: assert property (cs_n_o |-> sclk_o)
      else $error("serial clock low while deselected");
   a_clock_selected: assert property ($fell(sclk_o) |-> !cs_n_o)
      else $error("serial clock falls while deselected");
   // Whole words of 32 edges, several while select is held, or one short word.
   a_word_length: assert property ($rose(cs_n_o) |->
      rise_r != 7'h00 && (rise_r[4:0] == 5'h00 || rise_r == 7'h10))
      else $error("wrong count of rising edges in a word");
   a_data_stable: assert property ($rose(sclk_o) |-> $stable(mosi_o))
      else $error("host data changes at rising clock");
   a_reset_idle: assert property ($fell(rst_i) |->
      sclk_o && cs_n_o && mosi_o && !ack_o)
      else $error("outputs not idle after reset");
   a_freeze_holds: assert property (!ce_i |=>
      $stable({sclk_o, cs_n_o, mosi_o, ack_o}))
      else $error("outputs move while the clock enable is low");
endmodule
bind ecg_frame_host ecg_frame_host_monitor i_mon (.clk_i, .rst_i, .ce_i,
   .cyc_i, .stb_i, .ack_o, .sclk_o, .cs_n_o, .mosi_o);

// ===== sim/ecg_device_model.sv
`timescale 1ns/1ps
module ecg_device_model
(
   // Serial link from the host
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   // Answers to the host
   output logic miso_o,
   output logic frame_ready_low_o
);
   logic [23:0] regs [128];
   logic [31:0] in_r;
   logic [31:0] out_r;
   int rises;
   int falls;
   initial
   begin
      miso_o = 1'b1;
      out_r = 32'h0;
      rises = 0;
      falls = 0;
   end
   // Framing is never enabled, so commands are always welcome.
   assign frame_ready_low_o = 1'b0;
   // A full word is acted on at its last rising edge, so a write lands
   // whether select rises after it or stays low into the next word.
   always @(posedge sclk_i)
   begin
      if (!cs_n_i)
      begin
         in_r = {in_r[30:0], mosi_i};
         rises++;
         if (rises == 32)
         begin
            out_r = 32'h0;
            if (in_r[31])
               regs[in_r[30:24]] = in_r[23:0];
            else if (in_r[30:24] != 7'h00)
               out_r = {1'b0, in_r[30:24], regs[in_r[30:24]]};
            rises = 0;
            falls = 0;
         end
      end
   end
   always @(negedge sclk_i)
   begin
      if (!cs_n_i)
      begin
         miso_o <= out_r[5'd31 - falls[4:0]];
         falls++;
      end
   end
   // A word cut short by select is dropped together with any answer.
   always @(posedge cs_n_i)
   begin
      if (rises != 0)
         out_r = 32'h0;
      rises = 0;
      falls = 0;
      miso_o <= ~miso_o;
   end
endmodule

// ===== sim/ecg_frame_host_bench.sv
`timescale 1ns/1ps
module ecg_frame_host_bench
   import ecg_host_pkg::*;
();
   logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i;
   logic ack_o, sclk_o, cs_n_o, mosi_o, miso, ready_n;
   logic [3:0] adr_i, sel_i;
   logic [31:0] dat_i, dat_o, q;
   int fail_count, n_compared;
   ecg_frame_host i_dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sclk_o, .cs_n_o, .mosi_o,
      .miso_i(miso), .frame_ready_low_i(ready_n));
   ecg_device_model i_dev (.sclk_i(sclk_o), .cs_n_i(cs_n_o),
      .mosi_i(mosi_o), .miso_o(miso), .frame_ready_low_o(ready_n));
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("unexpected %0t got %h want %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a,
      input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hf;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1)
         @(posedge clk_i);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   // Sends one word, waits for it to finish and checks what came back.
   task automatic word(input logic [31:0] cmd, input logic [31:0] exp);
      wb(1'b1, REG_CMD, cmd);
      q = 32'h0;
      while (q[ST_DONE] !== 1'b1)
         wb(1'b0, REG_STATUS, 32'h0);
      wb(1'b0, REG_RDATA, 32'h0);
      chk(q, exp);
   endtask
   task automatic t_reset;
      chk({29'h0, sclk_o, cs_n_o, mosi_o}, 32'h7);
      wb(1'b0, REG_CTRL, 32'h0);
      chk(q, {24'h0, DIV_RESET});
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q, 32'h2);
      wb(1'b0, 4'h6, 32'h0);
      chk(q, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_write_read;
      word({1'b1, ADDR_PIN_STATE_WORD, 24'h5a3c96}, 32'h0);
      word({1'b0, ADDR_PIN_STATE_WORD, 24'h0}, 32'h0);
      word(32'h0, {1'b0, ADDR_PIN_STATE_WORD, 24'h5a3c96});
      word(32'h0, 32'h0);
      $display("write read test done");
   endtask
   task automatic t_pipeline;
      word({1'b1, ADDR_ELECTRODE_OFF_STATUS, 24'hc3a501}, 32'h0);
      word({1'b0, ADDR_ELECTRODE_OFF_STATUS, 24'h0}, 32'h0);
      word({1'b0, ADDR_PIN_STATE_WORD, 24'h0},
         {1'b0, ADDR_ELECTRODE_OFF_STATUS, 24'hc3a501});
      word(32'h0, {1'b0, ADDR_PIN_STATE_WORD, 24'h5a3c96});
      $display("pipeline test done");
   endtask
   // Sixty-four ones with a freeze of the clock enable near the start.
   task automatic t_resync;
      wb(1'b1, REG_CTRL, {21'h0, 3'b100, DIV_RESET});
      wb(1'b1, REG_CMD, 32'hffffffff);
      repeat (10) @(posedge clk_i);
      ce_i <= 1'b0;
      @(posedge clk_i);
      q = {29'h0, sclk_o, cs_n_o, mosi_o};
      chk({30'h0, q[1:0]}, 32'h1);
      repeat (20) @(posedge clk_i);
      chk({29'h0, sclk_o, cs_n_o, mosi_o}, q);
      ce_i <= 1'b1;
      q = 32'h0;
      while (q[ST_DONE] !== 1'b1)
         wb(1'b0, REG_STATUS, 32'h0);
      wb(1'b0, REG_RDATA, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, REG_CTRL, 32'h0);
      chk(q, {24'h0, DIV_RESET});
      wb(1'b0, REG_CMD, 32'h0);
      chk(q, 32'hffffffff);
      word({1'b0, ADDR_PIN_STATE_WORD, 24'h0}, 32'h0);
      word(32'h0, {1'b0, ADDR_PIN_STATE_WORD, 24'h5a3c96});
      $display("resync test done");
   endtask
   // A short word takes the upper half of the answer; its write is dropped.
   task automatic t_short;
      word({1'b0, ADDR_PIN_STATE_WORD, 24'h0}, 32'h0);
      wb(1'b1, REG_CTRL, {21'h0, 3'b001, DIV_RESET});
      word({1'b1, ADDR_PIN_STATE_WORD, 24'h123456},
         {16'h0, 1'b0, ADDR_PIN_STATE_WORD, 8'h5a});
      wb(1'b1, REG_CTRL, {24'h0, DIV_RESET});
      word({1'b0, ADDR_PIN_STATE_WORD, 24'h0}, 32'h0);
      word(32'h0, {1'b0, ADDR_PIN_STATE_WORD, 24'h5a3c96});
      $display("short word test done");
   endtask
   task automatic t_keep_select;
      wb(1'b1, REG_CTRL, {21'h0, 3'b010, DIV_RESET});
      word({1'b0, ADDR_ELECTRODE_OFF_STATUS, 24'h0}, 32'h0);
      word(32'h0, {1'b0, ADDR_ELECTRODE_OFF_STATUS, 24'hc3a501});
      chk({31'h0, cs_n_o}, 32'h0);
      wb(1'b1, REG_CTRL, {24'h0, DIV_RESET});
      word(32'h0, 32'h0);
      chk({31'h0, cs_n_o}, 32'h1);
      $display("keep select test done");
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      ce_i = 1'b1;
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 4'h0;
      sel_i = 4'hf;
      dat_i = 32'h0;
      fail_count = 0;
      n_compared = 0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_write_read();
      t_pipeline();
      t_resync();
      t_short();
      t_keep_select();
      finish_test();
   end
   // All scenarios take about 5000 cycles; this leaves a wide margin.
   initial
   begin
      #2000000;
      fail_count++;
      finish_test();
   end
endmodule
